// >>> rtl/osst_pkg.sv
// Purpose: shared constants for the oscillator source switch and trim block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: byte offsets and write field positions live here; read words pack fields by position in osst_top
package osst_pkg;
   localparam logic [7:0] OSST_ADDR_TRIM = 8'h38;
   localparam logic [7:0] OSST_ADDR_STAT = 8'h3c;
   localparam logic [7:0] OSST_ADDR_CFG = 8'h40;
   localparam logic [7:0] OSST_TRIM_RESET = 8'h80;
   localparam int OSST_BIT_REQ = 0;
   localparam int OSST_BIT_ENG = 1;
   localparam int OSST_BIT_OUTEN = 2;
   localparam int OSST_SEL_LO = 0;
   localparam int OSST_SEL_HI = 1;
   localparam logic [1:0] OSST_SRC_INT = 2'h0;
   localparam logic [1:0] OSST_SRC_EXT = 2'h1;
   localparam logic [1:0] OSST_SRC_RC = 2'h2;
   localparam logic [1:0] OSST_SRC_XTAL = 2'h3;
   localparam logic [1:0] OSST_EDGES_NEEDED = 2'h2;
   typedef enum logic [1:0] {
      OSST_ST_INT = 2'b00,
      OSST_ST_WAIT = 2'b01,
      OSST_ST_HAND = 2'b11,
      OSST_ST_EXT = 2'b10
   } osst_state_e;
endpackage

// >>> rtl/osst_top.sv
// Purpose: clock source select, one-way internal to external switch, trim register
// Assumes: source clocks arrive as levels sampled on CLK; CLK far faster than sources
// Notes: x4 and x2 are clock-rate levels regenerated in the CLK domain
// Summary of operation
// - trim is eight bits, steps +127 and -128 around the midpoint
// - larger trim lengthens internal period, smaller shortens it
// - reset loads trim with 0x80
// - selection makes input pin a clock input; crystal also takes output pin
// - after request, wait two external rising edges before switching
// - switch internal to external without glitch or runt pulse
// - set engaged status first, then stop the internal oscillator; internal enable drops with engaged, run flag one cycle later
// - only reset restarts internal oscillator; no fallback on external loss
// - direct external mode: x4 is input pin clock, x2 is half of it
// - direct external mode: output pin is port bit four, enable ignored
// - crystal mode: output pin is amplifier output, enable ignored
// - internal or RC mode: enable 0 gives port bit four, 1 gives x4
// - oscillator enable input gates whichever source is selected
// - x4 equals the internal clock until the switch, then the selected source clock, to the system unit
// - x2 runs at half the x4 frequency, to the system unit
// - wait mode leaves both clocks running
// - stop mode disables the selected source, hence x2 and x4
// - debug break leaves both clocks running
// - select decodes 00 internal, 01 external, 10 RC, 11 crystal
// - switch request bit is read/write and cleared by reset
// - engaged status is read-only, one while external drives system clock
// - out of reset the internal oscillator is selected
module osst_top
   import osst_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic OSC_IN_PIN,
   input wire logic INTERNAL_SOURCE_CLOCK,
   input wire logic RC_SOURCE_CLOCK,
   input wire logic CRYSTAL_SOURCE_CLOCK,
   input wire logic OSC_ENABLE_FROM_SYSINT,
   input wire logic STOP_MODE,
   input wire logic WAIT_MODE,
   input wire logic BREAK_STATE,
   input wire logic PORT_A_BIT4_OUT,
   input wire logic PORT_A_BIT4_OE_N,
   output logic OSC_OUT_PIN_O,
   output logic OSC_OUT_PIN_OE_N,
   output logic OSC_IN_IS_CLOCK,
   output logic OUT_PIN_IS_XTAL_AMP,
   output logic [7:0] INTERNAL_OSC_TRIM,
   output logic INTERNAL_OSC_RUN,
   output logic INTERNAL_OSC_ENABLE,
   output logic RC_OSC_ENABLE,
   output logic XTAL_OSC_ENABLE,
   output logic CORE_CLOCK_X4,
   output logic CORE_CLOCK_X2
);
   import osst_pkg::*;

   logic [7:0] trim_reg;
   logic [1:0] sel_reg;
   logic req_reg;
   logic outen_reg;
   logic eng_reg;
   logic int_run_reg;
   osst_state_e state_reg, state_next;
   logic req_s1_reg, req_s2_reg;
   logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
   logic [1:0] edge_cnt_reg;
   logic int_s1_reg, int_s2_reg;
   logic x4_reg, x4_d_reg, x2_reg;
   logic use_ext_reg;
   logic [31:0] prdata_reg;

   // apb decode, zero wait states
   wire acc = PSEL && PENABLE;
   wire wr = acc && PWRITE;
   wire hit_trim = (PADDR == OSST_ADDR_TRIM);
   wire hit_stat = (PADDR == OSST_ADDR_STAT);
   wire hit_cfg = (PADDR == OSST_ADDR_CFG);
   wire hit_any = hit_trim || hit_stat || hit_cfg;
   wire wr_trim = wr && hit_trim;
   wire wr_stat = wr && hit_stat;
   wire wr_cfg = wr && hit_cfg;

   assign PREADY = 1'b1;
   assign PSLVERR = acc && !hit_any;
   assign PRDATA = prdata_reg;

   wire [31:0] rd_stat = {30'h0, eng_reg, req_reg};
   wire [31:0] rd_cfg = {29'h0, outen_reg, sel_reg};
   wire [31:0] rd_mux = hit_trim ? {24'h0, trim_reg} :
                        hit_stat ? rd_stat :
                        hit_cfg ? rd_cfg : 32'h0;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         prdata_reg <= 32'h0;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         prdata_reg <= rd_mux;
      end
   end

   // trim: field passes straight to the capacitor bank, higher means longer period
   always_ff @(posedge CLK) begin
      if (SRST) begin
         trim_reg <= OSST_TRIM_RESET;
      end else if (wr_trim) begin
         trim_reg <= PWDATA[7:0];
      end
   end
   assign INTERNAL_OSC_TRIM = trim_reg;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         sel_reg <= OSST_SRC_INT;
         outen_reg <= 1'b0;
         req_reg <= 1'b0;
      end else begin
         if (wr_cfg) begin
            sel_reg <= PWDATA[OSST_SEL_HI:OSST_SEL_LO];
            outen_reg <= PWDATA[OSST_BIT_OUTEN];
         end
         if (wr_stat) begin
            req_reg <= PWDATA[OSST_BIT_REQ];
         end
      end
   end

   // source decode
   wire is_int = (sel_reg == OSST_SRC_INT);
   wire is_ext = (sel_reg == OSST_SRC_EXT);
   wire is_rc = (sel_reg == OSST_SRC_RC);
   wire is_xtal = (sel_reg == OSST_SRC_XTAL);

   assign OSC_IN_IS_CLOCK = !is_int;
   assign OUT_PIN_IS_XTAL_AMP = is_xtal;

   // source that feeds the external edge chain
   wire ext_src = is_ext ? OSC_IN_PIN :
                  is_rc ? RC_SOURCE_CLOCK :
                  is_xtal ? CRYSTAL_SOURCE_CLOCK : 1'b0;

   // synchronisers: first stage read only by second
   always_ff @(posedge CLK) begin
      if (SRST) begin
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         ext_s3_reg <= 1'b0;
         int_s1_reg <= 1'b0;
         int_s2_reg <= 1'b0;
      end else begin
         req_s1_reg <= req_reg;
         req_s2_reg <= req_s1_reg;
         ext_s1_reg <= ext_src;
         ext_s2_reg <= ext_s1_reg;
         ext_s3_reg <= ext_s2_reg;
         int_s1_reg <= INTERNAL_SOURCE_CLOCK;
         int_s2_reg <= int_s1_reg;
      end
   end

   wire ext_rise = ext_s2_reg && !ext_s3_reg;
   wire run_ok = OSC_ENABLE_FROM_SYSINT && !STOP_MODE;
   wire last_edge = (edge_cnt_reg == OSST_EDGES_NEEDED - 2'h1);
   // swap only while x4 and both sources sit low: no runt high phase either side
   wire hand_ok = !x4_reg && !int_s2_reg && !ext_s2_reg;

   // switch sequencer: one-way
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         OSST_ST_INT: begin
            if (req_s2_reg && !is_int) begin
               state_next = OSST_ST_WAIT;
            end
         end
         OSST_ST_WAIT: begin
            if (ext_rise && last_edge) begin
               state_next = OSST_ST_HAND;
            end
         end
         OSST_ST_HAND: begin
            if (hand_ok) begin
               state_next = OSST_ST_EXT;
            end
         end
         OSST_ST_EXT: begin
            state_next = OSST_ST_EXT;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_reg <= OSST_ST_INT;
         edge_cnt_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         if (state_reg == OSST_ST_WAIT && ext_rise) begin
            edge_cnt_reg <= edge_cnt_reg + 2'h1;
         end
      end
   end

   // engaged first, internal run flag clears one cycle later
   always_ff @(posedge CLK) begin
      if (SRST) begin
         use_ext_reg <= 1'b0;
         eng_reg <= 1'b0;
         int_run_reg <= 1'b1;
      end else begin
         if (state_reg == OSST_ST_HAND && hand_ok) begin
            use_ext_reg <= 1'b1;
            eng_reg <= 1'b1;
         end
         if (eng_reg) begin
            int_run_reg <= 1'b0;
         end
      end
   end
   assign INTERNAL_OSC_RUN = int_run_reg;

   // enables to analog sources
   assign INTERNAL_OSC_ENABLE = run_ok && int_run_reg && !use_ext_reg;
   assign RC_OSC_ENABLE = run_ok && is_rc;
   assign XTAL_OSC_ENABLE = run_ok && is_xtal;

   // x4 follows the live source; switch only happens while x4 is low
   wire src_live = use_ext_reg ? ext_s2_reg : int_s2_reg;
   wire x4_next = run_ok && src_live;
   always_ff @(posedge CLK) begin
      if (SRST) begin
         x4_reg <= 1'b0;
         x4_d_reg <= 1'b0;
         x2_reg <= 1'b0;
      end else begin
         x4_reg <= x4_next;
         x4_d_reg <= x4_reg;
         if (x4_reg && !x4_d_reg) begin
            x2_reg <= !x2_reg;
         end
      end
   end
   assign CORE_CLOCK_X4 = x4_reg;
   assign CORE_CLOCK_X2 = x2_reg;

   // output pin function
   wire pin_x4 = (is_int || is_rc) && outen_reg;
   assign OSC_OUT_PIN_O = is_xtal ? 1'b0 : pin_x4 ? x4_reg : PORT_A_BIT4_OUT;
   assign OSC_OUT_PIN_OE_N = is_xtal ? 1'b1 : pin_x4 ? 1'b0 : PORT_A_BIT4_OE_N;

   // wait and break need no gating
   wire unused_ok = WAIT_MODE ^ BREAK_STATE;

   // reset values and register writes
   a_trim_reset: assert property (
      @(posedge CLK) $past(SRST) |-> trim_reg == OSST_TRIM_RESET)
      else $error("trim not midpoint after reset");

   a_req_clear: assert property (
      @(posedge CLK) $past(SRST) |-> !req_reg && !eng_reg)
      else $error("request not cleared");

   a_trim_write: assert property (
      @(posedge CLK) disable iff (SRST)
      wr_trim |=> trim_reg == $past(PWDATA[7:0]))
      else $error("trim write lost");

   // switch sequence
   a_two_edges: assert property (
      @(posedge CLK) disable iff (SRST)
      $rose(eng_reg) |-> edge_cnt_reg == OSST_EDGES_NEEDED)
      else $error("switched before two edges");

   a_switch_low: assert property (
      @(posedge CLK) disable iff (SRST)
      $rose(use_ext_reg) |-> !$past(x4_reg) && !$past(int_s2_reg) && !$past(ext_s2_reg) && !x4_reg)
      else $error("switch at high clock");

   a_eng_before_stop: assert property (
      @(posedge CLK) disable iff (SRST)
      $rose(eng_reg) |-> int_run_reg ##1 !int_run_reg)
      else $error("internal stopped before engaged");

   a_int_enable_off: assert property (
      @(posedge CLK) disable iff (SRST)
      eng_reg |-> !INTERNAL_OSC_ENABLE)
      else $error("internal enabled after switch");

   a_no_fallback: assert property (
      @(posedge CLK) disable iff (SRST)
      eng_reg |=> eng_reg && !int_run_reg)
      else $error("fell back to internal");

   a_state_oneway: assert property (
      @(posedge CLK) disable iff (SRST)
      state_reg == OSST_ST_EXT |=> state_reg == OSST_ST_EXT && eng_reg)
      else $error("sequencer left external state");

   // clock outputs
   a_x4_ext_src: assert property (
      @(posedge CLK) disable iff (SRST)
      run_ok && use_ext_reg |=> x4_reg == $past(ext_s2_reg))
      else $error("x4 not following external source");

   a_x4_int_src: assert property (
      @(posedge CLK) disable iff (SRST)
      run_ok && !use_ext_reg |=> x4_reg == $past(int_s2_reg))
      else $error("x4 not following internal source");

   a_x2_half_rate: assert property (
      @(posedge CLK) disable iff (SRST)
      x4_reg && !x4_d_reg |=> x2_reg != $past(x2_reg))
      else $error("x2 missed an x4 rise");

   a_x2_steady: assert property (
      @(posedge CLK) disable iff (SRST)
      !(x4_reg && !x4_d_reg) |=> $stable(x2_reg))
      else $error("x2 toggled without x4 rise");

   a_wait_break_run: assert property (
      @(posedge CLK) disable iff (SRST)
      (WAIT_MODE || BREAK_STATE) && run_ok |=> x4_reg == $past(src_live))
      else $error("x4 gated in wait or break");

   a_stop_gates: assert property (
      @(posedge CLK) disable iff (SRST)
      STOP_MODE ##1 STOP_MODE |-> !x4_reg)
      else $error("x4 running in stop");

   a_stop_enables: assert property (
      @(posedge CLK) disable iff (SRST)
      STOP_MODE |-> !INTERNAL_OSC_ENABLE && !RC_OSC_ENABLE && !XTAL_OSC_ENABLE)
      else $error("source enabled in stop");

   a_enable_gates: assert property (
      @(posedge CLK) disable iff (SRST)
      !OSC_ENABLE_FROM_SYSINT |-> !INTERNAL_OSC_ENABLE && !RC_OSC_ENABLE && !XTAL_OSC_ENABLE ##1 !x4_reg)
      else $error("source runs while disabled");

   // pin function
   a_pin_roles: assert property (
      @(posedge CLK) disable iff (SRST)
      OSC_IN_IS_CLOCK == (sel_reg != OSST_SRC_INT) && OUT_PIN_IS_XTAL_AMP == (sel_reg == OSST_SRC_XTAL))
      else $error("pin roles wrong for select");

   a_ext_pin_port: assert property (
      @(posedge CLK) disable iff (SRST)
      is_ext |-> OSC_OUT_PIN_O == PORT_A_BIT4_OUT && OSC_OUT_PIN_OE_N == PORT_A_BIT4_OE_N)
      else $error("external mode pin not port bit");

   a_xtal_pin: assert property (
      @(posedge CLK) disable iff (SRST)
      is_xtal |-> OSC_OUT_PIN_OE_N)
      else $error("crystal pin driven");

   a_pin_x4: assert property (
      @(posedge CLK) disable iff (SRST)
      (is_int || is_rc) && outen_reg |-> !OSC_OUT_PIN_OE_N && OSC_OUT_PIN_O == x4_reg)
      else $error("x4 not on pin");

   // main scenarios reached
   c_switch: cover property (@(posedge CLK) disable iff (SRST) $rose(eng_reg));
   c_x2_toggle: cover property (@(posedge CLK) disable iff (SRST) $rose(x2_reg));
   c_pin_x4: cover property (@(posedge CLK) disable iff (SRST) pin_x4 && x4_reg);
   c_stop: cover property (@(posedge CLK) disable iff (SRST) STOP_MODE && use_ext_reg);
   c_xtal_run: cover property (@(posedge CLK) disable iff (SRST) is_xtal && use_ext_reg);
endmodule

// >>> verification/osst_far_model.sv
// Purpose: far-side sources: internal, RC, crystal and external pin clocks
// Assumes: every source is much slower than CLK
// Notes: the pin clock rests low while stopped, never at a stale level
module osst_far_model #(
   parameter int P_INT = 16,
   parameter int P_RC = 20,
   parameter int P_XTAL = 24,
   parameter int P_EXT = 12
) (
   input wire logic CLK,
   input wire logic EXT_RUN,
   output logic INT_CLK,
   output logic RC_CLK,
   output logic XTAL_CLK,
   output logic EXT_CLK
);
   timeunit 1ns;
   timeprecision 100ps;
   int c_int = 0;
   int c_rc = 0;
   int c_xtal = 0;
   int c_ext = 0;
   always @(posedge CLK) begin
      c_int <= (c_int + 1) % P_INT;
      c_rc <= (c_rc + 1) % P_RC;
      c_xtal <= (c_xtal + 1) % P_XTAL;
      c_ext <= EXT_RUN ? (c_ext + 1) % P_EXT : 0;
   end
   assign INT_CLK = c_int < P_INT / 2;
   assign RC_CLK = c_rc < P_RC / 2;
   assign XTAL_CLK = c_xtal < P_XTAL / 2;
   assign EXT_CLK = EXT_RUN && c_ext >= P_EXT / 2;
endmodule

// >>> verification/test_osc_source_switch_trim.sv
// Purpose: self-checking bench for the source switch and trim block
// Assumes: zero-wait APB slave, source clocks from the far model
// Notes: clock rates checked by counting x4/x2 rises over a fixed window
module test_osc_source_switch_trim;
   timeunit 1ns;
   timeprecision 100ps;
   import osst_pkg::*;
   localparam int P_INT = 16, P_RC = 20, P_XTAL = 24, P_EXT = 12, WIN = 480;
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [7:0] paddr = 8'h00, trim;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic osc_in, int_clk, rc_clk, xtal_clk, ext_run = 0, osc_en = 1, stop = 0;
   logic wait_m = 0, brk = 0, port_out = 0, port_oe_n = 0;
   logic out_o, out_oe_n, in_is_clk, is_amp, osc_run, x4, x2;
   logic int_en, rc_en, xt_en;
   logic [7:0] tv [4] = '{8'h00, 8'h7f, 8'hff, 8'h81};
   int n_errors = 0, tests_run = 0, r4 = 0, r2 = 0, n;
   always #2 clk = ~clk;
   always @(posedge x4) r4++;
   always @(posedge x2) r2++;
   osst_top i_osst_top (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .OSC_IN_PIN(osc_in),
      .INTERNAL_SOURCE_CLOCK(int_clk), .RC_SOURCE_CLOCK(rc_clk),
      .CRYSTAL_SOURCE_CLOCK(xtal_clk), .OSC_ENABLE_FROM_SYSINT(osc_en),
      .STOP_MODE(stop), .WAIT_MODE(wait_m), .BREAK_STATE(brk),
      .PORT_A_BIT4_OUT(port_out), .PORT_A_BIT4_OE_N(port_oe_n),
      .OSC_OUT_PIN_O(out_o), .OSC_OUT_PIN_OE_N(out_oe_n), .OSC_IN_IS_CLOCK(in_is_clk),
      .OUT_PIN_IS_XTAL_AMP(is_amp), .INTERNAL_OSC_TRIM(trim), .INTERNAL_OSC_RUN(osc_run),
      .INTERNAL_OSC_ENABLE(int_en), .RC_OSC_ENABLE(rc_en), .XTAL_OSC_ENABLE(xt_en),
      .CORE_CLOCK_X4(x4), .CORE_CLOCK_X2(x2));
   osst_far_model #(.P_INT(P_INT), .P_RC(P_RC), .P_XTAL(P_XTAL), .P_EXT(P_EXT))
      i_osst_far_model (.CLK(clk), .EXT_RUN(ext_run), .INT_CLK(int_clk),
      .RC_CLK(rc_clk), .XTAL_CLK(xtal_clk), .EXT_CLK(osc_in));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      check(rd, exp);
   endtask
   // counts rises of x4 and x2 over a whole number of source periods
   task automatic measure(input int p);
      int a4, a2;
      repeat (40) @(posedge clk);
      a4 = r4;
      a2 = r2;
      repeat (WIN) @(posedge clk);
      check(r4 - a4, p ? WIN / p : 0);
      check(r2 - a2, p ? WIN / (2 * p) : 0);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 0;
      rd_chk(OSST_ADDR_TRIM, 32'h80);
      check(trim, 8'h80);
      rd_chk(OSST_ADDR_STAT, 32'h0);
      rd_chk(OSST_ADDR_CFG, 32'h0);
      check(osc_run, 1'b1);
      check({int_en, rc_en, xt_en}, 3'b100);
      for (int i = 0; i < 4; i++) begin
         apb(OSST_ADDR_TRIM, 1'b1, {24'h5a0000, tv[i]});
         rd_chk(OSST_ADDR_TRIM, {24'h0, tv[i]});
         check(trim, tv[i]);
      end
      apb(8'h44, 1'b0, 32'h0);
      check({err, rd}, {1'b1, 32'h0});
      apb(OSST_ADDR_STAT, 1'b1, 32'h2);
      rd_chk(OSST_ADDR_STAT, 32'h0);
      apb(OSST_ADDR_STAT, 1'b1, 32'h1);
      repeat (64) @(posedge clk);
      rd_chk(OSST_ADDR_STAT, 32'h1);
      check(osc_run, 1'b1);
      apb(OSST_ADDR_STAT, 1'b1, 32'h0);
      for (int s = 0; s < 4; s++) begin
         for (int e = 0; e < 2; e++) begin
            port_out <= e[0];
            port_oe_n <= e[0];
            apb(OSST_ADDR_CFG, 1'b1, 32'(s) | (32'(e) << OSST_BIT_OUTEN));
            @(posedge clk);
            check(in_is_clk, s != 0);
            check(is_amp, s == 3);
            check({rc_en, xt_en}, {s == 2, s == 3});
            check(out_oe_n, s == 3 || (s == 1 && e == 1));
            if (s != 3) check(out_o, (s != 1 && e) ? x4 : port_out);
         end
      end
      apb(OSST_ADDR_CFG, 1'b1, 32'h0);
      measure(P_INT);
      wait_m <= 1;
      brk <= 1;
      measure(P_INT);
      wait_m <= 0;
      brk <= 0;
      stop <= 1;
      measure(0);
      check(int_en, 1'b0);
      stop <= 0;
      osc_en <= 0;
      measure(0);
      check(int_en, 1'b0);
      osc_en <= 1;
      apb(OSST_ADDR_CFG, 1'b1, 32'h1);
      repeat (100) @(posedge clk);
      apb(OSST_ADDR_STAT, 1'b1, 32'h1);
      repeat (200) @(posedge clk);
      rd_chk(OSST_ADDR_STAT, 32'h1);
      ext_run <= 1;
      n = 0;
      while (osc_run !== 1'b0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      check(osc_run, 1'b0);
      rd_chk(OSST_ADDR_STAT, 32'h3);
      measure(P_EXT);
      apb(OSST_ADDR_CFG, 1'b1, 32'h2);
      measure(P_RC);
      check({int_en, rc_en, xt_en}, 3'b010);
      port_out <= 1;
      port_oe_n <= 0;
      @(posedge clk);
      check({out_oe_n, out_o}, 2'b01);
      apb(OSST_ADDR_CFG, 1'b1, 32'h3);
      measure(P_XTAL);
      check({int_en, rc_en, xt_en}, 3'b001);
      ext_run <= 0;
      apb(OSST_ADDR_CFG, 1'b1, 32'h1);
      measure(0);
      check({int_en, rc_en, xt_en}, 3'b000);
      rd_chk(OSST_ADDR_STAT, 32'h3);
      check(osc_run, 1'b0);
      srst <= 1;
      repeat (4) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      check(osc_run, 1'b1);
      check({int_en, rc_en, xt_en}, 3'b100);
      rd_chk(OSST_ADDR_STAT, 32'h0);
      measure(P_INT);
      tally_and_finish();
   end
endmodule
